// [rtl/ptc_bus_if.sv]
// Processor I/O bus between host end and controller end
`timescale 1ns/1ps
`default_nettype none
interface ptc_bus_if;
  logic [7:0] hostDataLines;
  logic addressStrobe;
  logic commandStrobe;
  logic statusRequest;
  logic dataRequestLine;
  logic dataAvailableLine;
  logic systemClearLine;
  logic [7:0] returnDataLines;
  logic acknowledgeSync;
  logic attentionLine;

  modport device (
    input hostDataLines, addressStrobe, commandStrobe, statusRequest,
    input dataRequestLine, dataAvailableLine, systemClearLine,
    output returnDataLines, acknowledgeSync, attentionLine
  );
  modport host (
    output hostDataLines, addressStrobe, commandStrobe, statusRequest,
    output dataRequestLine, dataAvailableLine, systemClearLine,
    input returnDataLines, acknowledgeSync, attentionLine
  );
endinterface
`default_nettype wire

// [rtl/ptc_device_end.sv]
// Controller end: address match, command/status, reader and punch data paths
`timescale 1ns/1ps
`default_nettype none

module ptc_device_end #(
  parameter logic [7:0] DEV_ADDR = ptc_pkg::DEV_ADDR_DEF,
  parameter logic [ptc_pkg::CNT_W-1:0] WARM_CYC = ptc_pkg::WARM_CYC,
  parameter logic [ptc_pkg::CNT_W-1:0] RECYC_CYC = ptc_pkg::RECYC_CYC,
  parameter logic [ptc_pkg::CNT_W-1:0] READY_CYC = ptc_pkg::READY_CYC,
  parameter logic [ptc_pkg::CNT_W-1:0] GATE_CYC = ptc_pkg::GATE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  ptc_bus_if.device bus,
  input wire logic sprocketSync,
  input wire logic [7:0] readerChannelBits,
  output logic feedRequest,
  output logic punchPowerFlag,
  input wire logic punchVoltageOk,
  input wire logic punchSyncN,
  output logic [7:0] punchChannelDrive,
  output logic feedGatePulse
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic addrMatch, writeSel, punchPower, attention, overrun;
    logic runFlag, slewFlag, intEnable, devTransmit, bufFull, feed;
    logic [7:0] buffer;
    logic [1:0] sprSync;
    logic sprPrev;
    logic [7:0] chan1, chan2;
    logic [1:0] vckSync, psySync;
    logic psyPrev;
    logic [ptc_pkg::SPROCKET_STROBE_W-1:0] strobeCnt;
    logic [ptc_pkg::CNT_W-1:0] readyCnt, gateCnt, warmCnt;
    logic warmReady, warmDone, timerFlag;
    logic [ptc_pkg::ACK_W-1:0] ackCnt;
    logic ackSync;
    logic [7:0] retData;
    logic drPrev, attnLine, feedGate;
    logic [7:0] punchDrive;
  } ptc_dev_state_t;

  ptc_dev_state_t s;
  ptc_dev_state_t next_s;
  logic [7:0] cmd;
  logic [7:0] status;
  logic wrNew, busy, sprEdge, drG, srG, daG, reqAny, ackNow, readyActive;

  assign feedRequest = s.feed;
  assign punchPowerFlag = s.punchPower;
  assign punchChannelDrive = s.punchDrive;
  assign feedGatePulse = s.feedGate;
  assign bus.returnDataLines = s.retData;
  assign bus.acknowledgeSync = s.ackSync;
  assign bus.attentionLine = s.attnLine;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    cmd = bus.hostDataLines;
    wrNew = s.writeSel;
    // Channel bits go through the same two stages as sprocket sync to stay aligned
    next_s.sprSync = {s.sprSync[0], sprocketSync};
    next_s.sprPrev = s.sprSync[1];
    next_s.chan1 = readerChannelBits;
    next_s.chan2 = s.chan1;
    next_s.vckSync = {s.vckSync[0], punchVoltageOk};
    next_s.psySync = {s.psySync[0], punchSyncN};
    next_s.psyPrev = s.psySync[1];
    // Strobe is not retriggerable, so a bouncing sprocket loads once
    sprEdge = s.sprSync[1] & ~s.sprPrev & (s.strobeCnt == '0);
    drG = bus.dataRequestLine & s.addrMatch;
    srG = bus.statusRequest & s.addrMatch;
    daG = bus.dataAvailableLine & s.addrMatch;
    reqAny = drG | srG | daG;
    ackNow = reqAny & (s.ackCnt == ptc_pkg::ACK_CYC - 1'b1);
    busy = s.writeSel ? (s.bufFull | ~s.warmDone) : s.devTransmit;
    status = 8'h00;
    status[ptc_pkg::ST_OVERRUN] = s.overrun & ~s.writeSel;
    status[ptc_pkg::ST_NO_MOTION] = ~s.writeSel & ~s.feed;
    status[ptc_pkg::ST_BUSY] = busy;
    status[ptc_pkg::ST_EXTRA] = 1'b0;
    status[ptc_pkg::ST_UNAVAIL] = s.writeSel & s.punchPower & ~s.vckSync[1];

    // Address strap compare
    if (bus.addressStrobe) begin
      next_s.addrMatch = (bus.hostDataLines == DEV_ADDR);
    end

    // Recycle also runs under power, so an early write cannot leave busy stuck
    if (!s.punchPower) begin
      next_s.warmDone = 1'b0;
    end
    if (!s.warmReady && !next_s.warmDone) begin
      if (s.warmCnt >= RECYC_CYC - 1'b1) begin
        next_s.warmReady = 1'b1;
        next_s.warmCnt = '0;
      end else begin
        next_s.warmCnt = s.warmCnt + 1'b1;
      end
    end else if (s.punchPower && s.warmReady && s.vckSync[1]) begin
      if (s.warmCnt >= WARM_CYC - 1'b1) begin
        next_s.warmReady = 1'b0;
        next_s.warmDone = 1'b1;
        next_s.warmCnt = '0;
      end else begin
        next_s.warmCnt = s.warmCnt + 1'b1;
      end
    end

    // Command decode
    if (bus.commandStrobe && s.addrMatch) begin
      if (cmd[ptc_pkg::CMD_WRITE]) begin
        wrNew = 1'b1;
      end else if (cmd[ptc_pkg::CMD_READ]) begin
        wrNew = 1'b0;
      end
      if (wrNew != s.writeSel) begin
        next_s.attention = 1'b0;
        next_s.bufFull = 1'b0;
        next_s.intEnable = 1'b0;
        next_s.runFlag = 1'b0;
        next_s.slewFlag = 1'b0;
        next_s.devTransmit = 1'b1;
        next_s.warmCnt = '0;
      end
      next_s.writeSel = wrNew;
      next_s.punchPower = wrNew;
      if (cmd[ptc_pkg::CMD_DISABLE]) begin
        next_s.intEnable = 1'b0;
      end
      if (cmd[ptc_pkg::CMD_ENABLE]) begin
        next_s.intEnable = 1'b1;
      end
      if (cmd[ptc_pkg::CMD_STOP]) begin
        next_s.runFlag = 1'b0;
      end
      if (cmd[ptc_pkg::CMD_RUN]) begin
        next_s.runFlag = 1'b1;
      end
      if (cmd[ptc_pkg::CMD_SINGLE_STEP_MODE]) begin
        next_s.slewFlag = 1'b0;
      end
      if (cmd[ptc_pkg::CMD_SLEW]) begin
        next_s.slewFlag = 1'b1;
      end
    end

    // Request handshake; answers are taken and held until the request drops
    if (reqAny) begin
      if (s.ackCnt != ptc_pkg::ACK_CYC) begin
        next_s.ackCnt = s.ackCnt + 1'b1;
      end
      if (ackNow) begin
        next_s.ackSync = 1'b1;
        next_s.attention = 1'b0;
        if (srG) begin
          next_s.retData = status;
          next_s.overrun = 1'b0;
        end else if (drG) begin
          next_s.retData = s.buffer;
        end else if (s.writeSel && !s.bufFull) begin
          next_s.buffer = cmd;
          next_s.bufFull = 1'b1;
        end
      end
    end else begin
      next_s.ackCnt = '0;
      next_s.ackSync = 1'b0;
      next_s.retData = 8'h00;
    end
    next_s.drPrev = drG;
    if (s.drPrev && !drG) begin
      next_s.devTransmit = 1'b1;
    end

    // Reader strobe and buffer load
    if (sprEdge) begin
      next_s.strobeCnt = ptc_pkg::SPROCKET_STROBE_CYC;
    end else if (s.strobeCnt != '0) begin
      next_s.strobeCnt = s.strobeCnt - 1'b1;
    end
    if (sprEdge && !s.writeSel) begin
      next_s.buffer = s.chan2;
      if (!s.devTransmit) begin
        next_s.overrun = 1'b1;
      end
      next_s.devTransmit = 1'b0;
    end

    // Punch ready shaping and gating timer
    if (s.psyPrev && !s.psySync[1] && s.readyCnt == '0) begin
      next_s.readyCnt = READY_CYC;
    end else if (s.readyCnt != '0) begin
      next_s.readyCnt = s.readyCnt - 1'b1;
    end
    readyActive = (s.readyCnt != '0);
    if (s.timerFlag) begin
      if (s.gateCnt <= 1) begin
        next_s.timerFlag = 1'b0;
        next_s.gateCnt = '0;
        next_s.bufFull = 1'b0;
      end else begin
        next_s.gateCnt = s.gateCnt - 1'b1;
      end
    end else if (readyActive && s.bufFull && s.writeSel && s.warmDone) begin
      next_s.timerFlag = 1'b1;
      next_s.gateCnt = GATE_CYC;
    end
    next_s.punchDrive = next_s.timerFlag ? s.buffer : 8'h00;
    next_s.feedGate = next_s.timerFlag;

    // Attention events come last so that a set beats any clear above
    if ((sprEdge && !s.writeSel) || (wrNew && !s.writeSel)) begin
      next_s.attention = 1'b1;
    end
    if ((s.timerFlag && s.gateCnt <= 1) || (s.warmCnt >= WARM_CYC - 1'b1 && s.punchPower
        && s.warmReady && s.vckSync[1])) begin
      next_s.attention = 1'b1;
    end

    // Feed: step mode stops once transmit clears and restarts when it sets again
    next_s.feed = next_s.runFlag & ~next_s.writeSel
                & (next_s.slewFlag | next_s.devTransmit);
    next_s.attnLine = next_s.attention & next_s.intEnable;

    if (bus.systemClearLine) begin
      next_s = '0;
      next_s.devTransmit = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.devTransmit <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule // ptc_device_end
`default_nettype wire

// [rtl/ptc_host_end.sv]
// Host end: turns user operations into bus sequences for the controller
`timescale 1ns/1ps
`default_nettype none
module ptc_host_end #(
  parameter logic [7:0] DEV_ADDR = ptc_pkg::DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  ptc_bus_if.host bus,
  input wire logic opStart,
  input wire logic [1:0] opKind,
  input wire logic [7:0] opData,
  input wire logic sysClear,
  output logic opBusy,
  output logic opDone,
  output logic opTimeout,
  output logic [7:0] opResult,
  output logic irqPending
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {IDLE, ADDR, ISSUE, WAITACK, DONE} ptc_host_fsm_t;

  typedef struct packed {
    ptc_host_fsm_t fsm;
    logic [1:0] kind;
    logic [7:0] data;
    logic [7:0] host_data_lines;
    logic addrStb, cmdStb, statReq, dataReq, dataAvail, sysClr;
    logic [7:0] tmo;
    logic busy, done, timeout, irq;
    logic [7:0] result;
  } ptc_host_state_t;

  ptc_host_state_t s;
  ptc_host_state_t next_s;

  assign bus.hostDataLines = s.host_data_lines;
  assign bus.addressStrobe = s.addrStb;
  assign bus.commandStrobe = s.cmdStb;
  assign bus.statusRequest = s.statReq;
  assign bus.dataRequestLine = s.dataReq;
  assign bus.dataAvailableLine = s.dataAvail;
  assign bus.systemClearLine = s.sysClr;
  assign opBusy = s.busy;
  assign opDone = s.done;
  assign opTimeout = s.timeout;
  assign opResult = s.result;
  assign irqPending = s.irq;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.addrStb = 1'b0;
    next_s.cmdStb = 1'b0;
    next_s.done = 1'b0;
    next_s.sysClr = sysClear;
    next_s.irq = bus.attentionLine;
    case (s.fsm)
      IDLE: begin
        if (opStart) begin
          next_s.kind = opKind;
          next_s.data = opData;
          next_s.host_data_lines = DEV_ADDR;
          next_s.addrStb = 1'b1;
          next_s.busy = 1'b1;
          next_s.timeout = 1'b0;
          next_s.fsm = ADDR;
        end
      end
      ADDR: begin
        // Data lines settle a cycle before the command strobe or a request; the address goes out with its strobe
        next_s.host_data_lines = s.data;
        next_s.fsm = ISSUE;
      end
      ISSUE: begin
        next_s.tmo = '0;
        next_s.fsm = WAITACK;
        case (s.kind)
          ptc_pkg::OP_COMMAND: begin
            next_s.cmdStb = 1'b1;
            next_s.fsm = DONE;
          end
          ptc_pkg::OP_STATUS: next_s.statReq = 1'b1;
          ptc_pkg::OP_READ: next_s.dataReq = 1'b1;
          ptc_pkg::OP_WRITE: next_s.dataAvail = 1'b1;
          default: next_s.fsm = DONE;
        endcase
      end
      WAITACK: begin
        next_s.tmo = s.tmo + 1'b1;
        // An unmatched address never answers, so give up rather than hang
        if (bus.acknowledgeSync || s.tmo == ptc_pkg::HOST_TMO_CYC) begin
          next_s.result = bus.returnDataLines;
          next_s.timeout = ~bus.acknowledgeSync;
          next_s.statReq = 1'b0;
          next_s.dataReq = 1'b0;
          next_s.dataAvail = 1'b0;
          next_s.fsm = DONE;
        end
      end
      DONE: begin
        next_s.done = 1'b1;
        next_s.busy = 1'b0;
        next_s.fsm = IDLE;
      end
      default: next_s.fsm = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // ptc_host_end
`default_nettype wire

// [rtl/ptc_pkg.sv]
// Shared constants for the paper tape reader/punch controller and its host end
package ptc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int SPROCKET_STROBE_NS = 400;
  localparam int ACK_NS = 200;
  localparam int WARM_MS = 1000;
  localparam int RECYC_MS = 10;
  localparam int READY_US = 1000;
  localparam int GATE_US = 4500;
  localparam int CNT_W = 26;
  localparam int SPROCKET_STROBE_W = 5;
  localparam int ACK_W = 4;
  // Least times round up, longest times round down
  localparam logic [SPROCKET_STROBE_W-1:0] SPROCKET_STROBE_CYC = SPROCKET_STROBE_W'((SPROCKET_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [ACK_W-1:0] ACK_CYC = ACK_W'((ACK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WARM_CYC = CNT_W'((WARM_MS * 1000000 + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RECYC_CYC = CNT_W'(RECYC_MS * 1000000 / CLK_NS);
  localparam logic [CNT_W-1:0] READY_CYC = CNT_W'(READY_US * 1000 / CLK_NS);
  localparam logic [CNT_W-1:0] GATE_CYC = CNT_W'(GATE_US * 1000 / CLK_NS);
  localparam logic [7:0] HOST_TMO_CYC = 8'hFF;

  // ****************************************
  // Address strap and byte layouts
  // ****************************************
  localparam logic [7:0] DEV_ADDR_DEF = 8'h4C;
  localparam int CMD_DISABLE = 0;
  localparam int CMD_ENABLE = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_RUN = 3;
  localparam int CMD_SINGLE_STEP_MODE = 4;
  localparam int CMD_SLEW = 5;
  localparam int CMD_WRITE = 6;
  localparam int CMD_READ = 7;
  localparam int ST_OVERRUN = 0;
  localparam int ST_NO_MOTION = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_EXTRA = 5;
  localparam int ST_UNAVAIL = 7;

  // ****************************************
  // Host operation kinds
  // ****************************************
  localparam logic [1:0] OP_COMMAND = 2'h0;
  localparam logic [1:0] OP_STATUS = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;

endpackage

// [testbench/ptc_sva.sv]
// Concurrent checks on the bus joining the host end and the controller end
`timescale 1ns/1ps
`default_nettype none
module ptc_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] hostDataLines,
  input wire logic commandStrobe,
  input wire logic statusRequest,
  input wire logic dataRequestLine,
  input wire logic dataAvailableLine,
  input wire logic systemClearLine,
  input wire logic [7:0] returnDataLines,
  input wire logic acknowledgeSync,
  input wire logic attentionLine
);
  // ****************************************
  // Helpers
  // ****************************************
  wire logic anyReq;
  assign anyReq = statusRequest | dataRequestLine | dataAvailableLine;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Assertions
  // ****************************************
  a_ack_delay: assert property (
    $rose(anyReq) |-> !acknowledgeSync [*8] ##[1:4] acknowledgeSync)
    else $error("acknowledge delay wrong");
  a_ack_cause: assert property (
    $rose(acknowledgeSync) |-> anyReq)
    else $error("acknowledge without request");
  a_ack_holds: assert property (
    acknowledgeSync && anyReq |=> acknowledgeSync)
    else $error("acknowledge dropped early");
  a_ack_release: assert property (
    $fell(anyReq) |=> !acknowledgeSync)
    else $error("acknowledge held too long");
  a_ret_idle: assert property (
    !acknowledgeSync |-> returnDataLines == 8'h00)
    else $error("return lines driven while idle");
  a_clear_quiet: assert property (
    systemClearLine |=> !attentionLine && !acknowledgeSync)
    else $error("clear left bus active");
  a_status_unused: assert property (
    acknowledgeSync && statusRequest |-> (returnDataLines & 8'h66) == 8'h00)
    else $error("unused status bits set");
  a_irq_masked: assert property (
    commandStrobe && hostDataLines[ptc_pkg::CMD_DISABLE]
      && !hostDataLines[ptc_pkg::CMD_ENABLE] |-> ##2 !attentionLine [*2])
    else $error("interrupt shown while disabled");
  // ****************************************
  // Covers
  // ****************************************
  c_read: cover property ($rose(acknowledgeSync) && dataRequestLine);
  c_write: cover property ($rose(acknowledgeSync) && dataAvailableLine);
  c_status: cover property ($rose(acknowledgeSync) && statusRequest);
endmodule // ptc_sva
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the controller end and host end pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk, nrst, opStart, sysClear, sprocketSync, punchVoltageOk, punchSyncN;
  logic [1:0] opKind;
  logic [7:0] opData, readerChannelBits, opResult, punchChannelDrive, res;
  logic opBusy, opDone, opTimeout, irqPending, feedRequest, punchPowerFlag, feedGatePulse;
  int bad_count = 0;
  int num_checks = 0;
  ptc_bus_if busIf();
  // Short counts keep warm-up and punch cycle brief; gate stays longer than ready
  ptc_device_end #(.WARM_CYC(26'h32), .RECYC_CYC(26'h14), .READY_CYC(26'hA),
    .GATE_CYC(26'h1E)) ptc_device_end_inst (.clk(clk), .nrst(nrst), .bus(busIf),
    .sprocketSync(sprocketSync), .readerChannelBits(readerChannelBits),
    .feedRequest(feedRequest), .punchPowerFlag(punchPowerFlag),
    .punchVoltageOk(punchVoltageOk), .punchSyncN(punchSyncN),
    .punchChannelDrive(punchChannelDrive), .feedGatePulse(feedGatePulse));
  ptc_host_end ptc_host_end_inst (.clk(clk), .nrst(nrst), .bus(busIf),
    .opStart(opStart), .opKind(opKind), .opData(opData), .sysClear(sysClear),
    .opBusy(opBusy), .opDone(opDone), .opTimeout(opTimeout), .opResult(opResult),
    .irqPending(irqPending));
  ptc_sva ptc_sva_inst (.clk(clk), .nrst(nrst), .hostDataLines(busIf.hostDataLines),
    .commandStrobe(busIf.commandStrobe), .statusRequest(busIf.statusRequest),
    .dataRequestLine(busIf.dataRequestLine), .dataAvailableLine(busIf.dataAvailableLine),
    .systemClearLine(busIf.systemClearLine), .returnDataLines(busIf.returnDataLines),
    .acknowledgeSync(busIf.acknowledgeSync), .attentionLine(busIf.attentionLine));
  // ****************************************
  // Common tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded so that a silent device cannot hang the run
  task automatic wt(ref logic s, input logic v);
    int i;
    for (i = 0; i < 200 && s !== v; i++) @(posedge clk);
    if (i == 200) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] d);
    int i;
    opStart <= 1'b1;
    opKind <= k;
    opData <= d;
    @(posedge clk);
    opStart <= 1'b0;
    @(posedge clk);
    chkb("opBusy", 1'b1, opBusy);
    for (i = 0; i < 400 && opDone !== 1'b1; i++) @(posedge clk);
    if (i == 400) begin
      bad_count++;
      summarize();
    end
    chkb("opTimeout", 1'b0, opTimeout);
    chkb("opBusy", 1'b0, opBusy);
    res = opResult;
  endtask
  task automatic st(input logic [7:0] e);
    op(ptc_pkg::OP_STATUS, 8'h00);
    chk("status", e, res);
  endtask
  // Sprocket pulses spaced well past the ignore window
  task automatic spr(input logic [7:0] d);
    readerChannelBits <= d;
    sprocketSync <= 1'b1;
    tick(3);
    sprocketSync <= 1'b0;
    tick(25);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_idle();
    st(8'h18);
    chkb("feed", 1'b0, feedRequest);
    chkb("power", 1'b0, punchPowerFlag);
  endtask
  task automatic s_step();
    op(ptc_pkg::OP_COMMAND, 8'h1A);
    tick(3);
    chkb("feed", 1'b1, feedRequest);
    spr(8'hA5);
    wt(irqPending, 1'b1);
    chkb("feed", 1'b0, feedRequest);
    op(ptc_pkg::OP_COMMAND, 8'h01);
    tick(2);
    chkb("irq", 1'b0, irqPending);
    op(ptc_pkg::OP_COMMAND, 8'h02);
    tick(2);
    chkb("irq", 1'b1, irqPending);
    st(8'h08);
    op(ptc_pkg::OP_READ, 8'h00);
    chk("rdata", 8'hA5, res);
    tick(3);
    chkb("feed", 1'b1, feedRequest);
    st(8'h10);
    op(ptc_pkg::OP_COMMAND, 8'h04);
    tick(3);
    chkb("feed", 1'b0, feedRequest);
  endtask
  task automatic s_overrun();
    op(ptc_pkg::OP_COMMAND, 8'h28);
    spr(8'h3C);
    spr(8'hC3);
    st(8'h01);
    st(8'h00);
    op(ptc_pkg::OP_READ, 8'h00);
    chk("rdata", 8'hC3, res);
  endtask
  task automatic s_clear();
    sysClear <= 1'b1;
    tick(3);
    sysClear <= 1'b0;
    tick(2);
    chkb("irq", 1'b0, irqPending);
    s_idle();
  endtask
  task automatic s_punch();
    op(ptc_pkg::OP_COMMAND, 8'h4A);
    tick(2);
    chkb("power", 1'b1, punchPowerFlag);
    wt(irqPending, 1'b1);
    st(8'h10);
    tick(60);
    st(8'h00);
    op(ptc_pkg::OP_WRITE, 8'h96);
    st(8'h10);
    // A second byte into a full buffer is answered but must not be kept
    op(ptc_pkg::OP_WRITE, 8'h69);
    punchSyncN <= 1'b0;
    tick(4);
    punchSyncN <= 1'b1;
    wt(feedGatePulse, 1'b1);
    tick(1);
    chk("punch", 8'h96, punchChannelDrive);
    wt(feedGatePulse, 1'b0);
    chk("punch", 8'h00, punchChannelDrive);
    tick(2);
    chkb("irq", 1'b1, irqPending);
    st(8'h00);
    punchVoltageOk <= 1'b0;
    tick(4);
    op(ptc_pkg::OP_STATUS, 8'h00);
    chkb("unavail", 1'b1, res[ptc_pkg::ST_UNAVAIL]);
    punchVoltageOk <= 1'b1;
  endtask
  task automatic s_back();
    op(ptc_pkg::OP_COMMAND, 8'h80);
    tick(2);
    chkb("power", 1'b0, punchPowerFlag);
    chkb("irq", 1'b0, irqPending);
    st(8'h18);
  endtask
  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    opStart = 1'b0;
    opKind = 2'h0;
    opData = 8'h00;
    sysClear = 1'b0;
    sprocketSync = 1'b0;
    readerChannelBits = 8'h00;
    punchVoltageOk = 1'b1;
    punchSyncN = 1'b1;
    tick(2);
    nrst <= 1'b1;
    tick(2);
    s_idle();
    s_step();
    s_overrun();
    s_clear();
    s_punch();
    s_back();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
